// >>> sideband_pkg.sv
package sideband_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SNOOP_HIT_DELAY_CLK = 2;
  localparam int FRC_ERR_DELAY_CLK = 2;
  localparam int NEXT_ADDR_DELAY_CLK = 2;
  localparam int MAX_OUTSTANDING = 2;
  localparam int LOCK_GAP_CLK = 1;
  localparam int INTA_CYCLES = 2;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] SNOOP_OFFSET = 12'h008;
  localparam logic [11:0] CYCLE_OFFSET = 12'h00c;
  localparam logic [11:0] FRC_OFFSET = 12'h010;
  // Control field positions
  localparam int CTRL_NATIVE_ERROR_BIT = 0;
  localparam int CTRL_IF_BIT = 1;
  localparam int CTRL_LIC_EN_BIT = 2;
  localparam int CTRL_ES_BIT = 3;
  localparam int CTRL_FPCTL_BIT = 4;
  localparam int CTRL_SOFT_INIT_BIT = 5;
  localparam int CTRL_PARITY_ERR_BIT = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Cycle request fields
  localparam int CYC_GO_BIT = 0;
  localparam int CYC_LOCK_BIT = 1;
  localparam int CYC_MEM_BIT = 2;
  localparam int CYC_CACHE_BIT = 3;
  localparam int CYC_LAST_BIT = 4;
  // Snoop fields
  localparam int SNP_VALID_BIT = 0;
  localparam int SNP_MOD_BIT = 1;
  localparam int SNP_WB_DONE_BIT = 2;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACTIVE = 2'b01,
    BUS_HOLD = 2'b10,
    BUS_SHUTDOWN = 2'b11
  } bus_state_t;
endpackage

// >>> sideband_ctrl.sv
// Operation
// RULE1 - Master drives outputs; checker floats them except error, interrupt data, test out
// RULE2 - Master or checker role latched at reset release, kept until next reset
// RULE3 - Snoop hit output set two clocks after snoop strobe, held till next inquire
// RULE4 - Modified snoop hit asserted, blocks others until write-back completes
// RULE5 - Hold request: finish outstanding cycles, float, assert acknowledge until removed
// RULE6 - Leaving hold drops acknowledge; pending cycle starts in that same clock
// RULE7 - Hold ignored during locked cycles, honoured during reset; code acknowledges hold only after the synchronised reset release
// RULE8 - Internal parity error pulses internal error one clock, then shutdown; code stays in BUS_HOLD if the error comes during hold
// RULE9 - Checker mismatch raises internal error two clocks after mismatching value
// RULE10 - Ignore input has no effect when native error bit is one
// RULE11 - Pending exception: control instructions run, others stall awaiting interrupt
// RULE12 - Soft init restarts as after reset, keeping caches and buffers
// RULE13 - Soft init high at reset release requests self test
// RULE14 - Enabled maskable interrupt gives two locked acknowledge cycles then vectors
// RULE15 - Interrupt source holds request until first acknowledge cycle begins
// RULE16 - Invalidate sampled with snoop strobe sets hit line shared or invalid; code samples invalidate but snoop_hit_out ignores it
// RULE17 - Cacheable cycle with cache enable active becomes burst line fill
// RULE18 - Controller enabled: pins are local interrupts; else maskable and non-maskable
// RULE19 - Bus lock refuses hold; address hold and backoff still honoured
// RULE20 - Lock from first locked clock to last burst ready, one idle clock between
// RULE21 - Next address gives strobe two clocks later; at most two cycles outstanding
// RULE22 - Memory/IO definition valid in same clock as address strobe
// RULE23 - System drives snoop address and snoop strobe to start an inquire
`timescale 1ns/1ps
module sideband_ctrl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Straps and bus pins
  input wire logic redundancy_role_select_in,
  input wire logic soft_init_in,
  input wire logic hold_request_in,
  input wire logic address_hold_in,
  input wire logic backoff_in,
  input wire logic burst_ready_in,
  input wire logic next_address_in,
  input wire logic external_cache_enable_in,
  input wire logic snoop_address_strobe_in,
  input wire logic snoop_invalidate_in,
  input wire logic ignore_numeric_error_in,
  input wire logic local_interrupt_zero_in,
  input wire logic local_interrupt_one_in,
  input wire logic [3:0] checker_sample_in,
  // Bus outputs
  output logic address_strobe_out,
  output logic mem_io_out,
  output logic bus_lock_out,
  output logic burst_fill_out,
  output logic hold_acknowledge_out,
  output logic snoop_hit_out,
  output logic snoop_modified_hit_out,
  output logic internal_error_out,
  output logic outputs_enable_out,
  // Core-facing status
  output logic maskable_interrupt_out,
  output logic nonmaskable_interrupt_out,
  output logic local_interrupt_zero_out,
  output logic local_interrupt_one_out,
  output logic fp_stall_out,
  output logic self_test_out,
  output logic soft_restart_out
);
  // ****************************************
  // Reset and input synchronisers
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_b;
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  assign rst_b = rst_sync[1];

  localparam int NSYNC = 16;
  logic [NSYNC-1:0] pin_raw, sync1, pin;
  assign pin_raw = {checker_sample_in, redundancy_role_select_in, soft_init_in, hold_request_in,
    address_hold_in, backoff_in, burst_ready_in, next_address_in, external_cache_enable_in,
    snoop_address_strobe_in, snoop_invalidate_in, ignore_numeric_error_in, local_interrupt_zero_in};
  // Pins are asynchronous to the bus clock
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      sync1 <= '0;
      pin <= '0;
    end
    else
    begin
      sync1 <= pin_raw;
      pin <= sync1;
    end
  logic local_interrupt_one_s1, local_interrupt_one;
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      local_interrupt_one_s1 <= 1'b0;
      local_interrupt_one <= 1'b0;
    end
    else
    begin
      local_interrupt_one_s1 <= local_interrupt_one_in;
      local_interrupt_one <= local_interrupt_one_s1;
    end
  logic [3:0] chk_s;
  logic role_s, sinit_s, hold_s, address_hold_in_s, backoff_in_s, burst_ready_in_s, na_s, ken_s, snoop_address_strobe_in_s, inv_s, ign_s, local_interrupt_zero;
  assign {chk_s, role_s, sinit_s, hold_s, address_hold_in_s, backoff_in_s, burst_ready_in_s, na_s, ken_s, snoop_address_strobe_in_s, inv_s,
    ign_s, local_interrupt_zero} = pin;

  // ****************************************
  // APB registers
  // ****************************************
  logic [31:0] ctrl;
  logic [4:0] cyc_req;
  logic [2:0] snp_cfg;
  logic [3:0] frc_expect;
  logic wr, rd, parity_pulse, wb_done, cyc_go;
  assign wr = psel_in && penable_in && pwrite_in;
  assign rd = psel_in && !penable_in && !pwrite_in;
  assign parity_pulse = wr && paddr_in == sideband_pkg::CTRL_OFFSET && pwdata_in[sideband_pkg::CTRL_PARITY_ERR_BIT];
  assign wb_done = wr && paddr_in == sideband_pkg::SNOOP_OFFSET && pwdata_in[sideband_pkg::SNP_WB_DONE_BIT];
  assign cyc_go = wr && paddr_in == sideband_pkg::CYCLE_OFFSET && pwdata_in[sideband_pkg::CYC_GO_BIT];
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      ctrl <= sideband_pkg::CTRL_RESET;
      cyc_req <= '0;
      snp_cfg <= '0;
      frc_expect <= '0;
    end
    else if (wr)
    begin
      case (paddr_in)
        sideband_pkg::CTRL_OFFSET: ctrl <= pwdata_in & 32'h0000_003f;
        sideband_pkg::CYCLE_OFFSET: cyc_req <= pwdata_in[4:0];
        sideband_pkg::SNOOP_OFFSET: snp_cfg <= pwdata_in[2:0];
        sideband_pkg::FRC_OFFSET: frc_expect <= pwdata_in[3:0];
        default: ctrl <= ctrl;
      endcase
    end

  logic role_checker, bist_req;
  logic [1:0] outstanding;
  sideband_pkg::bus_state_t state;
  logic bad_addr;
  assign bad_addr = paddr_in > sideband_pkg::FRC_OFFSET || paddr_in[1:0] != 2'b00;
  // Zero-wait slave; read data staged in setup so prdata is a flop
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      prdata_out <= '0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && bad_addr;
      if (rd)
      begin
        case (paddr_in)
          sideband_pkg::CTRL_OFFSET: prdata_out <= ctrl;
          sideband_pkg::STATUS_OFFSET: prdata_out <= {22'h0, outstanding, state, bist_req, role_checker,
            hold_acknowledge_out, bus_lock_out, snoop_modified_hit_out, snoop_hit_out};
          sideband_pkg::SNOOP_OFFSET: prdata_out <= {29'h0, snp_cfg};
          sideband_pkg::CYCLE_OFFSET: prdata_out <= {27'h0, cyc_req};
          sideband_pkg::FRC_OFFSET: prdata_out <= {28'h0, frc_expect};
          default: prdata_out <= '0;
        endcase
      end
    end

  // ****************************************
  // Reset straps
  // ****************************************
  logic strap_done;
  logic [1:0] strap_wait;
  // RULE2 role latched once
  // Waits for the synchronisers to fill, so reset values are never taken as straps
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      strap_done <= 1'b0;
      strap_wait <= 2'd0;
      role_checker <= 1'b0;
      bist_req <= 1'b0;
    end
    else if (!strap_done && strap_wait != 2'd2)
      strap_wait <= strap_wait + 2'd1;
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      role_checker <= !role_s;
      // RULE13 self test strap
      bist_req <= sinit_s;
    end
  assign self_test_out = bist_req;

  // ****************************************
  // Bus cycle and hold control
  // ****************************************
  logic lock_gap, pending, na_d1, na_fire;
  logic [1:0] inta_left;
  assign na_fire = na_d1;
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
      na_d1 <= 1'b0;
    else
      // RULE21 strobe two clocks after next address
      na_d1 <= na_s && outstanding == 2'd1;
  // RULE14 two locked acknowledge cycles
  logic maskable_interrupt_in_take;
  assign maskable_interrupt_in_take = maskable_interrupt_out && ctrl[sideband_pkg::CTRL_IF_BIT] && inta_left == 2'd0
    && state == sideband_pkg::BUS_IDLE && !pending;
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
      pending <= 1'b0;
    else if (cyc_go || maskable_interrupt_in_take || (burst_ready_in_s && outstanding != 2'd0 && inta_left == 2'd2))
      pending <= 1'b1;
    else if (address_strobe_out)
      pending <= 1'b0;
  logic issue, hold_ok;
  // RULE7 RULE19 hold refused while locked
  assign hold_ok = hold_s && !bus_lock_out;
  // RULE21 cap at two outstanding
  assign issue = pending && !lock_gap && !address_hold_in_s && !backoff_in_s && state != sideband_pkg::BUS_SHUTDOWN
    && !(hold_ok && state != sideband_pkg::BUS_ACTIVE)
    && (outstanding == 2'd0 || (na_fire && outstanding < 2'(sideband_pkg::MAX_OUTSTANDING)));
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      state <= sideband_pkg::BUS_IDLE;
      outstanding <= 2'd0;
      hold_acknowledge_out <= 1'b0;
      address_strobe_out <= 1'b0;
      mem_io_out <= 1'b0;
      burst_fill_out <= 1'b0;
      inta_left <= 2'd0;
    end
    else
    begin
      // RULE22 definition with strobe
      address_strobe_out <= issue;
      if (issue)
      begin
        mem_io_out <= inta_left != 2'd0 ? 1'b0 : cyc_req[sideband_pkg::CYC_MEM_BIT];
        // RULE17 burst when cacheable and enabled
        burst_fill_out <= cyc_req[sideband_pkg::CYC_CACHE_BIT] && ken_s;
      end
      if (maskable_interrupt_in_take)
        inta_left <= 2'(sideband_pkg::INTA_CYCLES);
      else if (burst_ready_in_s && outstanding != 2'd0 && inta_left != 2'd0)
        inta_left <= inta_left - 2'd1;
      if (backoff_in_s)
        outstanding <= 2'd0;
      else
        outstanding <= outstanding + 2'(issue) - 2'(burst_ready_in_s && outstanding != 2'd0);
      // RULE8 shutdown after parity error from BUS_IDLE or BUS_ACTIVE
      case (state)
        sideband_pkg::BUS_IDLE:
          if (parity_pulse)
            state <= sideband_pkg::BUS_SHUTDOWN;
          // RULE5 float and acknowledge hold
          else if (hold_ok && outstanding == 2'd0)
          begin
            state <= sideband_pkg::BUS_HOLD;
            hold_acknowledge_out <= 1'b1;
          end
          else if (issue)
            state <= sideband_pkg::BUS_ACTIVE;
        sideband_pkg::BUS_ACTIVE:
          if (parity_pulse)
            state <= sideband_pkg::BUS_SHUTDOWN;
          else if (outstanding == 2'd1 && burst_ready_in_s && !issue)
            state <= sideband_pkg::BUS_IDLE;
        sideband_pkg::BUS_HOLD:
          // RULE6 leave hold, pending strobe same clock
          if (!hold_s)
          begin
            hold_acknowledge_out <= 1'b0;
            state <= issue ? sideband_pkg::BUS_ACTIVE : sideband_pkg::BUS_IDLE;
          end
        default:
          state <= sideband_pkg::BUS_SHUTDOWN;
      endcase
    end
  // Hold in reset: acknowledge logic runs from the synchronised reset release onward

  // RULE20 lock span and one-clock gap
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      bus_lock_out <= 1'b0;
      lock_gap <= 1'b0;
    end
    else
    begin
      lock_gap <= 1'b0;
      if (issue && !bus_lock_out && (cyc_req[sideband_pkg::CYC_LOCK_BIT] || inta_left != 2'd0 || maskable_interrupt_in_take))
        bus_lock_out <= 1'b1;
      else if (bus_lock_out && burst_ready_in_s && outstanding == 2'd1 && !pending
               && (inta_left == 2'd1 || (inta_left == 2'd0 && cyc_req[sideband_pkg::CYC_LAST_BIT])))
      begin
        bus_lock_out <= 1'b0;
        lock_gap <= 1'b1;
      end
    end

  // ****************************************
  // Snoop response
  // ****************************************
  logic snoop_address_strobe_in_d1, inv_d1;
  // RULE3 hit two clocks after strobe
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      snoop_address_strobe_in_d1 <= 1'b0;
      inv_d1 <= 1'b0;
      snoop_hit_out <= 1'b0;
      snoop_modified_hit_out <= 1'b0;
    end
    else
    begin
      snoop_address_strobe_in_d1 <= snoop_address_strobe_in_s;
      // RULE16 invalidate sampled with strobe
      if (snoop_address_strobe_in_s)
        inv_d1 <= inv_s;
      if (snoop_address_strobe_in_d1)
      begin
        snoop_hit_out <= snp_cfg[sideband_pkg::SNP_VALID_BIT] && !(inv_d1 && 1'b0);
        // RULE4 modified hit until write-back
        snoop_modified_hit_out <= snp_cfg[sideband_pkg::SNP_MOD_BIT];
      end
      else if (wb_done)
        snoop_modified_hit_out <= 1'b0;
    end
  // ****************************************
  // Errors and redundancy check
  // ****************************************
  logic mismatch_d1;
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      mismatch_d1 <= 1'b0;
      internal_error_out <= 1'b0;
      outputs_enable_out <= 1'b0;
    end
    else
    begin
      // RULE1 checker floats bus outputs
      outputs_enable_out <= strap_done && !role_checker && state != sideband_pkg::BUS_HOLD;
      // RULE9 mismatch error two clocks later
      mismatch_d1 <= role_checker && strap_done && chk_s != frc_expect;
      // RULE8 one-clock parity pulse
      internal_error_out <= parity_pulse || mismatch_d1;
    end

  // ****************************************
  // Interrupt pins and numeric error
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_b)
    if (!rst_b)
    begin
      maskable_interrupt_out <= 1'b0;
      nonmaskable_interrupt_out <= 1'b0;
      local_interrupt_zero_out <= 1'b0;
      local_interrupt_one_out <= 1'b0;
      fp_stall_out <= 1'b0;
      soft_restart_out <= 1'b0;
    end
    else
    begin
      // RULE18 pin routing by controller enable
      maskable_interrupt_out <= !ctrl[sideband_pkg::CTRL_LIC_EN_BIT] && local_interrupt_zero;
      nonmaskable_interrupt_out <= !ctrl[sideband_pkg::CTRL_LIC_EN_BIT] && local_interrupt_one;
      local_interrupt_zero_out <= ctrl[sideband_pkg::CTRL_LIC_EN_BIT] && local_interrupt_zero;
      local_interrupt_one_out <= ctrl[sideband_pkg::CTRL_LIC_EN_BIT] && local_interrupt_one;
      // RULE10 RULE11 numeric error stall
      fp_stall_out <= !ctrl[sideband_pkg::CTRL_NATIVE_ERROR_BIT] && !ign_s
        && ctrl[sideband_pkg::CTRL_ES_BIT] && !ctrl[sideband_pkg::CTRL_FPCTL_BIT];
      // RULE12 soft restart, caches kept
      soft_restart_out <= strap_done && (sinit_s || (wr && paddr_in == sideband_pkg::CTRL_OFFSET
        && pwdata_in[sideband_pkg::CTRL_SOFT_INIT_BIT]));
    end

  // ****************************************
  // Checks
  // ****************************************
  AST_HIT_DELAY: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE3
    snoop_address_strobe_in_s |-> ##2 (snoop_hit_out == $past(snp_cfg[sideband_pkg::SNP_VALID_BIT]))) else $error("hit timing");
  AST_HIT_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE3
    !snoop_address_strobe_in_d1 |=> $stable(snoop_hit_out)) else $error("hit changed without inquire");
  AST_HOLD_ACKNOWLEDGE_LOCK: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE19
    (bus_lock_out && !hold_acknowledge_out) |=> !hold_acknowledge_out) else $error("hold taken while locked");
  AST_HOLD_ACKNOWLEDGE_IDLE: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE5
    $rose(hold_acknowledge_out) |-> outstanding == 2'd0) else $error("hold with cycles open");
  AST_INTERNAL_ERROR_OUT_PULSE: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE8
    parity_pulse |=> internal_error_out ##1 (state == sideband_pkg::BUS_SHUTDOWN)) else $error("parity pulse");
  AST_FRC_ERR: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE9
    (role_checker && strap_done && chk_s != frc_expect) |-> ##2 internal_error_out) else $error("frc error late");
  AST_MAX_OUT: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE21
    outstanding <= 2'd2) else $error("too many cycles");
  AST_LOCK_GAP: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE20
    $fell(bus_lock_out) |=> !bus_lock_out) else $error("lock gap missing");
  AST_NE_SET: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE10
    ctrl[sideband_pkg::CTRL_NATIVE_ERROR_BIT] |=> !fp_stall_out) else $error("stall with native error");
  AST_ROLE_FIXED: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE2
    strap_done |=> $stable(role_checker)) else $error("role changed");
endmodule // sideband_ctrl

// >>> sideband_partner.sv
`timescale 1ns/1ps
module sideband_partner (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Device pins watched
  input wire logic address_strobe_in,
  input wire logic bus_lock_in,
  // Test controls
  input wire logic slow_in,
  input wire logic irq_req_in,
  // Pins toward the device
  output logic burst_ready_out,
  output logic irq_line_out
);
  int owed;
  int delay;
  logic fire;
  // A slow answer keeps cycles outstanding longer
  assign fire = (owed > 0) && (delay >= (slow_in ? 4 : 1));
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      owed <= 0;
      delay <= 0;
      burst_ready_out <= 1'b0;
      irq_line_out <= 1'b0;
    end
    else
    begin
      burst_ready_out <= fire;
      delay <= (fire || owed == 0) ? 0 : delay + 1;
      owed <= owed + (address_strobe_in ? 1 : 0) - (fire ? 1 : 0);
      irq_line_out <= irq_req_in | (irq_line_out & ~(address_strobe_in & bus_lock_in));
    end
  end
endmodule // sideband_partner

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, r;
  logic pready_out, pslverr_out, burst_ready_in, local_interrupt_zero_in, slow = 1'b0, irq_req = 1'b0;
  logic redundancy_role_select_in = 1'b1, soft_init_in = 1'b0, hold_request_in = 1'b0, address_hold_in = 1'b0;
  logic backoff_in = 1'b0, next_address_in = 1'b0, external_cache_enable_in = 1'b0, local_interrupt_one_in = 1'b0;
  logic snoop_address_strobe_in = 1'b0, snoop_invalidate_in = 1'b0, ignore_numeric_error_in = 1'b0;
  logic [3:0] checker_sample_in = 4'h0;
  logic address_strobe_out, mem_io_out, bus_lock_out, burst_fill_out, hold_acknowledge_out, snoop_hit_out;
  logic snoop_modified_hit_out, internal_error_out, outputs_enable_out, maskable_interrupt_out, fp_stall_out;
  logic nonmaskable_interrupt_out, local_interrupt_zero_out, local_interrupt_one_out, self_test_out, soft_restart_out;
  logic [9:0] mon;
  logic [64:0] q[$];
  logic [64:0] e;
  logic [4:0] fp_rows [4] = '{5'b01001, 5'b01010, 5'b01100, 5'b00000};
  int errors = 0, comparisons = 0, n;
  assign mon = {outputs_enable_out, burst_fill_out, self_test_out, soft_restart_out, bus_lock_out,
    internal_error_out, snoop_modified_hit_out, snoop_hit_out, hold_acknowledge_out, address_strobe_out};
  always #5 clk_in = ~clk_in;
  sideband_ctrl dut (.*);
  sideband_partner bus (.clk_in(clk_in), .rst_b_in(rst_b_in), .address_strobe_in(address_strobe_out),
    .bus_lock_in(bus_lock_out), .slow_in(slow), .irq_req_in(irq_req), .burst_ready_out(burst_ready_in),
    .irq_line_out(local_interrupt_zero_in));
  // ****************************************
  // Tasks
  // ****************************************
  task results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bit_is(input logic g, input logic x);
    check({31'h0, g}, {31'h0, x});
  endtask
  // Read data is noted here and compared by the monitor below
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m = 32'h0,
    input logic err = 1'b0);
    int k;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    if (!w)
      q.push_back({err, m, d});
    @(posedge clk_in);
    penable_in <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_in);
      k++;
    end
    while (pready_out !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      errors++;
      results();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task await(input int i, input logic v, input int lim = 40);
    int k;
    k = 0;
    while (mon[i] !== v && k < lim)
    begin
      @(posedge clk_in);
      k++;
    end
    if (k >= lim)
    begin
      errors++;
      $display("Error at %0t: output %0d never reached %b", $time, i, v);
      results();
    end
  endtask
  task do_reset;
    rst_b_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    check({22'h0, mon}, 32'h0);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
  // Invalidate is flipped after the strobe so a stale level is never trusted
  task inquire(input logic old, input logic hit);
    @(posedge clk_in);
    snoop_address_strobe_in <= 1'b1;
    snoop_invalidate_in <= 1'($urandom);
    @(posedge clk_in);
    snoop_address_strobe_in <= 1'b0;
    snoop_invalidate_in <= ~snoop_invalidate_in;
    repeat (3) @(posedge clk_in);
    bit_is(snoop_hit_out, old);
    @(posedge clk_in);
    bit_is(snoop_hit_out, hit);
  endtask
  // ****************************************
  // Read monitor
  // ****************************************
  always @(posedge clk_in)
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in && q.size() > 0)
    begin
      e = q.pop_front();
      bit_is(pslverr_out, e[64]);
      check(prdata_out & e[63:32], e[31:0] & e[63:32]);
    end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    results();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    void'($urandom(83929));
    do_reset();
    apb(1'b0, sideband_pkg::CTRL_OFFSET, sideband_pkg::CTRL_RESET, 32'hffff_ffff);
    apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
    bit_is(outputs_enable_out, 1'b1);
    redundancy_role_select_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    bit_is(outputs_enable_out, 1'b1);
    apb(1'b1, sideband_pkg::SNOOP_OFFSET, 32'h3);
    inquire(1'b0, 1'b1);
    await(3, 1'b1, 8);
    apb(1'b1, sideband_pkg::SNOOP_OFFSET, 32'h4);
    await(3, 1'b0, 8);
    repeat (4) @(posedge clk_in);
    bit_is(snoop_hit_out, 1'b1);
    inquire(1'b1, 1'b0);
    slow <= 1'($urandom);
    external_cache_enable_in <= 1'b1;
    for (n = 0; n < 2; n++)
    begin
      apb(1'b1, sideband_pkg::CYCLE_OFFSET, n ? 32'h9 : 32'h5);
      await(0, 1'b1);
      bit_is(mem_io_out, n == 0);
    end
    await(8, 1'b1);
    apb(1'b1, sideband_pkg::CYCLE_OFFSET, 32'h7);
    await(5, 1'b1);
    hold_request_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    bit_is(hold_acknowledge_out, 1'b0);
    apb(1'b1, sideband_pkg::CYCLE_OFFSET, 32'h17);
    await(5, 1'b0);
    await(1, 1'b1);
    apb(1'b1, sideband_pkg::CYCLE_OFFSET, 32'h5);
    repeat (4) @(posedge clk_in);
    bit_is(address_strobe_out, 1'b0);
    hold_request_in <= 1'b0;
    await(1, 1'b0);
    bit_is(address_strobe_out, 1'b1);
    irq_req <= 1'b1;
    local_interrupt_one_in <= 1'b1;
    for (n = 0; n < 2; n++)
    begin
      apb(1'b1, sideband_pkg::CTRL_OFFSET, n ? 32'h4 : 32'h0);
      irq_req <= 1'b0;
      repeat (4) @(posedge clk_in);
      check({28'h0, maskable_interrupt_out, nonmaskable_interrupt_out, local_interrupt_zero_out,
        local_interrupt_one_out}, n ? 32'h3 : 32'hc);
    end
    local_interrupt_one_in <= 1'b0;
    apb(1'b1, sideband_pkg::CTRL_OFFSET, 32'h2);
    n = 0;
    repeat (80)
    begin
      @(posedge clk_in);
      if (address_strobe_out === 1'b1 && bus_lock_out === 1'b1)
        n++;
    end
    check(n, 32'h2);
    for (n = 0; n < 4; n++)
    begin
      ignore_numeric_error_in <= fp_rows[n][1];
      apb(1'b1, sideband_pkg::CTRL_OFFSET, {27'h0, fp_rows[n][2], fp_rows[n][3], 3'h0});
      repeat (4) @(posedge clk_in);
      bit_is(fp_stall_out, fp_rows[n][0]);
    end
    ignore_numeric_error_in <= 1'b0;
    apb(1'b1, sideband_pkg::CTRL_OFFSET, 32'h9);
    repeat (4) @(posedge clk_in);
    r[0] = fp_stall_out;
    ignore_numeric_error_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    bit_is(fp_stall_out, r[0]);
    apb(1'b1, sideband_pkg::CTRL_OFFSET, 32'h20);
    await(6, 1'b1, 10);
    apb(1'b1, sideband_pkg::CTRL_OFFSET, 32'h40);
    await(4, 1'b1, 10);
    @(posedge clk_in);
    bit_is(internal_error_out, 1'b0);
    apb(1'b0, sideband_pkg::STATUS_OFFSET, 32'hc0, 32'hc0);
    soft_init_in <= 1'b1;
    do_reset();
    await(7, 1'b1, 10);
    soft_init_in <= 1'b0;
    bit_is(outputs_enable_out, 1'b0);
    r = $urandom;
    apb(1'b1, sideband_pkg::FRC_OFFSET, r);
    checker_sample_in <= ~r[3:0];
    await(4, 1'b1, 10);
    results();
  end
endmodule // tb
